/* rtl/pcim_reg_bank.sv */
// Purpose: Configuration and interrupt enable bank of a clock synchroniser.
// Assumes: Byte accesses arrive already decoded from the serial port.
// Notes:   All outputs are flops; reads answer one cycle after the strobe.
// Summary of operation
// [R1] Limiter mask bit 4 enables history-update event.
// [R2] Bits 3,2 enable frequency unclamp, clamp events.
// [R3] Bits 1,0 enable slew stop, start events.
// [R4] Reference masks: secondary high nibble, primary low.
// [R5] Watchdog 16-bit milliseconds, zero disables.
// [R6] DAC full-scale 10 bits, resets to 511.
// [R7] DAC control bit 7 shuts current sources.
// [R8] Free-run word 48 bits, six bytes, zero.
// [R9] Transfer bit copies word, then self-clears.
// [R10] Free-run mode applies word without transfer.
// [R11] Pull-in limits 24 bits, defaults zero, 0xFFFFF.
// [R12] Open-loop phase offset 16 bits, zero.
// [R13] Fixed lock offset 40 bits picoseconds.
// [R14] Offset step 16 bits, resets to 1000.
// [R15] Slew limit 16 bits, zero disables.
// [R16] History timer 24 bits, 30000; never zero (the bank stores a written zero).
// [R17] Holdover without history: fallback bit picks word.
// [R18] Reference switch clears history unless persistent.
// [R19] History mode bits 2..0 hold averaging.
// [R20] Distribution bits 3..0 power down outputs.
// [R21] Distribution bit 4 selects receiver mode.
// [R22] Distribution bit 5 selects external resistor.
// [R23] Mask bits gate events, all reset zero.
// [R24] All four power-downs set means deep sleep.
// [R25] Unused bits read zero, ignore writes.
module pcim_reg_bank
  import pcim_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Register access port.
  input  wire logic [AW-1:0]        reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [DW-1:0]        reg_wdata,
  output logic      [DW-1:0]        reg_rdata_q,
  output logic                      reg_rvalid_q,
  // Raw events and their gated copies.
  input  wire logic [LIM_EVT_W-1:0] lim_evt,
  input  wire logic [REF_EVT_W-1:0] ref_evt,
  output logic      [LIM_EVT_W-1:0] lim_irq_evt_q,
  output logic      [REF_EVT_W-1:0] ref_irq_evt_q,
  // Loop status.
  input  wire logic                 freerun_mode,
  input  wire logic                 holdover_entry,
  input  wire logic                 history_avail,
  input  wire logic                 ref_switch,
  input  wire logic [TWW-1:0]       last_loop_word,
  // Watchdog and auxiliary DAC.
  output logic      [15:0]          watchdog_period_q,
  output logic                      watchdog_en_q,
  output logic      [DAC_W-1:0]     dac_fullscale_q,
  output logic                      dac_shutdown_q,
  // Loop settings.
  output logic      [TWW-1:0]       freerun_word_q,
  output logic      [TWW-1:0]       proc_word_q,
  output logic                      tw_load_q,
  output logic      [23:0]          pullin_lower_q,
  output logic      [23:0]          pullin_upper_q,
  output logic      [15:0]          open_loop_phase_q,
  output logic      [39:0]          fixed_lock_offset_q,
  output logic      [15:0]          offset_step_q,
  output logic      [15:0]          slew_limit_q,
  output logic                      slew_limit_en_q,
  output logic      [23:0]          history_timer_q,
  // History control.
  output logic                      hist_fallback_last_q,
  output logic                      hist_persist_q,
  output logic      [AVG_W-1:0]     hist_avg_q,
  output logic                      hist_clear_q,
  output logic      [TWW-1:0]       seed_word_q,
  output logic                      seed_valid_q,
  // Distribution.
  output logic      [NOUT-1:0]      out_powerdown_q,
  output logic                      rx_hf_mode_q,
  output logic                      ext_resistor_q,
  output logic                      dist_deep_sleep_q
);

  typedef struct packed {
    logic [NREG-1:0][DW-1:0] regs;
    logic [DW-1:0]           rd_data;
    logic                    rd_valid;
    logic [TWW-1:0]          proc_word;
    logic                    tw_load;
    logic [TWW-1:0]          seed_word;
    logic                    seed_valid;
    logic                    hist_clear;
    logic                    wd_en;
    logic                    slew_en;
    logic                    deep_sleep;
  } pcim_state_t;

  pcim_state_t    s_q;
  pcim_state_t    s_d;
  logic           xfer_wr;
  logic [TWW-1:0] fr_word;

  assign xfer_wr = reg_wr && (reg_addr == ADDR_TW_XFER)
                   && reg_wdata[BIT_XFER];
  assign fr_word = s_q.regs[IDX_FR0 +: TWW/DW];

  always_comb begin
    s_d            = s_q;
    s_d.rd_valid   = 1'b0;
    s_d.tw_load    = 1'b0;
    s_d.seed_valid = 1'b0;
    s_d.hist_clear = 1'b0;
    // Writes keep only defined bits so unused ones stay zero.
    for (int i = 0; i < NREG; i++) begin
      if (reg_wr && (reg_addr == REG_ADDR[i])) begin
        s_d.regs[i] = reg_wdata & REG_WMASK[i]; // [R25]
      end
    end
    // The transfer bit is never stored, so it reads back as zero.
    if (reg_rd) begin
      s_d.rd_valid = 1'b1;
      s_d.rd_data  = '0;
      for (int i = 0; i < NREG; i++) begin
        if (reg_addr == REG_ADDR[i]) begin
          s_d.rd_data = s_q.regs[i];
        end
      end
    end
    if (xfer_wr) begin
      s_d.proc_word = fr_word; // [R9]
      s_d.tw_load   = 1'b1; // [R9]
    end else if (freerun_mode) begin
      s_d.proc_word = fr_word; // [R10]
    end
    if (holdover_entry && !history_avail) begin
      s_d.seed_valid = 1'b1;
      s_d.seed_word  = s_q.regs[IDX_HMODE][BIT_FALLBACK] ?
                       last_loop_word : fr_word; // [R17]
    end
    if (ref_switch && !s_q.regs[IDX_HMODE][BIT_PERSIST]) begin
      s_d.hist_clear = 1'b1; // [R18]
    end
    s_d.wd_en      = |s_d.regs[IDX_WD0 +: 2]; // [R5]
    s_d.slew_en    = |s_d.regs[IDX_SLEW0 +: 2]; // [R15]
    s_d.deep_sleep = &s_d.regs[IDX_DIST][NOUT-1:0]; // [R24]
    if (!rstn) begin
      s_d = '0;
      for (int i = 0; i < NREG; i++) begin
        s_d.regs[i] = REG_RESET[i]; // [R23]
      end
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // Event enables; pair p uses mask byte p, secondary in the high nibble.
  pcim_evt_gate #(
    .W    (LIM_EVT_W)
  ) u_lim_gate (
    .clk  (clk),
    .rstn (rstn),
    .mask (s_q.regs[IDX_LIM][LIM_EVT_W-1:0]), // [R1] [R2] [R3]
    .evt  (lim_evt),
    .rec_q(lim_irq_evt_q)
  );

  pcim_evt_gate #(
    .W    (REF_EVT_W)
  ) u_ref_gate (
    .clk  (clk),
    .rstn (rstn),
    .mask (s_q.regs[IDX_REF0 +: REF_PAIRS]), // [R4]
    .evt  (ref_evt),
    .rec_q(ref_irq_evt_q)
  );

  assign reg_rdata_q          = s_q.rd_data;
  assign reg_rvalid_q         = s_q.rd_valid;
  assign watchdog_period_q    = s_q.regs[IDX_WD0 +: 2]; // [R5]
  assign watchdog_en_q        = s_q.wd_en;
  assign dac_fullscale_q      = {s_q.regs[IDX_DAC_CTL][DAC_W-DW-1:0],
                                 s_q.regs[IDX_DAC_LO]}; // [R6]
  assign dac_shutdown_q       = s_q.regs[IDX_DAC_CTL][BIT_DAC_SHDN]; // [R7]
  assign freerun_word_q       = fr_word; // [R8]
  assign proc_word_q          = s_q.proc_word;
  assign tw_load_q            = s_q.tw_load;
  assign pullin_lower_q       = s_q.regs[IDX_PLLO0 +: 3]; // [R11]
  assign pullin_upper_q       = s_q.regs[IDX_PLUP0 +: 3]; // [R11]
  assign open_loop_phase_q    = s_q.regs[IDX_OLP0 +: 2]; // [R12]
  assign fixed_lock_offset_q  = s_q.regs[IDX_FIX0 +: 5]; // [R13]
  assign offset_step_q        = s_q.regs[IDX_STEP0 +: 2]; // [R14]
  assign slew_limit_q         = s_q.regs[IDX_SLEW0 +: 2]; // [R15]
  assign slew_limit_en_q      = s_q.slew_en;
  assign history_timer_q      = s_q.regs[IDX_HT0 +: 3]; // [R16]
  assign hist_fallback_last_q = s_q.regs[IDX_HMODE][BIT_FALLBACK];
  assign hist_persist_q       = s_q.regs[IDX_HMODE][BIT_PERSIST];
  assign hist_avg_q           = s_q.regs[IDX_HMODE][AVG_W-1:0]; // [R19]
  assign hist_clear_q         = s_q.hist_clear;
  assign seed_word_q          = s_q.seed_word;
  assign seed_valid_q         = s_q.seed_valid;
  assign out_powerdown_q      = s_q.regs[IDX_DIST][NOUT-1:0]; // [R20]
  assign rx_hf_mode_q         = s_q.regs[IDX_DIST][BIT_RXMODE]; // [R21]
  assign ext_resistor_q       = s_q.regs[IDX_DIST][BIT_EXTRES]; // [R22]
  assign dist_deep_sleep_q    = s_q.deep_sleep;

  // Transfer write followed by a one-cycle load that then drops.
  sequence s_xfer_write;
    reg_wr && (reg_addr == ADDR_TW_XFER) && reg_wdata[BIT_XFER];
  endsequence

  property p_xfer_copy;
    @(posedge clk) disable iff (!rstn)
      s_xfer_write |=> tw_load_q && (proc_word_q == $past(freerun_word_q))
                       ##1 (!tw_load_q || $past(xfer_wr));
  endproperty
  a_xfer_copy: assert property (p_xfer_copy) // [R9]
    else $error("transfer write did not load word once");

  property p_freerun_follow;
    @(posedge clk) disable iff (!rstn)
      freerun_mode && !xfer_wr |=> proc_word_q == $past(freerun_word_q);
  endproperty
  a_freerun_follow: assert property (p_freerun_follow) // [R10]
    else $error("free-run word not applied in free-run mode");

  property p_deep_sleep;
    @(posedge clk) disable iff (!rstn)
      dist_deep_sleep_q == (out_powerdown_q == {NOUT{1'b1}});
  endproperty
  a_deep_sleep: assert property (p_deep_sleep) // [R24]
    else $error("deep sleep disagrees with power-down bits");

  property p_hist_clear;
    @(posedge clk) disable iff (!rstn)
      ref_switch |=> (hist_clear_q == !$past(hist_persist_q));
  endproperty
  a_hist_clear: assert property (p_hist_clear) // [R18]
    else $error("history clear wrong on reference switch");

  property p_seed;
    @(posedge clk) disable iff (!rstn)
      holdover_entry && !history_avail |=> seed_valid_q &&
        (seed_word_q == ($past(hist_fallback_last_q) ?
                         $past(last_loop_word) : $past(freerun_word_q)));
  endproperty
  a_seed: assert property (p_seed) // [R17]
    else $error("holdover seed word wrongly chosen");

  property p_reset_values;
    @(posedge clk) disable iff (!rstn)
      $past(!rstn) |-> (s_q.regs[IDX_LIM +: 5] == '0) &&
        (dac_fullscale_q == DAC_FS_RESET) &&
        (history_timer_q == HIST_TIMER_RESET) &&
        (offset_step_q == STEP_RESET) && !watchdog_en_q;
  endproperty
  a_reset_values: assert property (p_reset_values) // [R23]
    else $error("register bank reset values wrong");

  property p_unused_zero;
    @(posedge clk) disable iff (!rstn)
      ((s_q.regs[IDX_LIM] & ~REG_WMASK[IDX_LIM]) == '0) &&
      ((s_q.regs[IDX_DAC_CTL] & ~REG_WMASK[IDX_DAC_CTL]) == '0) &&
      ((s_q.regs[IDX_HMODE] & ~REG_WMASK[IDX_HMODE]) == '0) &&
      ((s_q.regs[IDX_DIST] & ~REG_WMASK[IDX_DIST]) == '0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) // [R25]
    else $error("unused register bits not zero");

  property p_read_xfer_zero;
    @(posedge clk) disable iff (!rstn)
      reg_rd && (reg_addr == ADDR_TW_XFER) |=>
        reg_rvalid_q && (reg_rdata_q == '0);
  endproperty
  a_read_xfer_zero: assert property (p_read_xfer_zero) // [R9]
    else $error("transfer register did not read back zero");

  property p_wd_en;
    @(posedge clk) disable iff (!rstn)
      watchdog_en_q == (watchdog_period_q != '0);
  endproperty
  a_wd_en: assert property (p_wd_en) // [R5]
    else $error("watchdog enable disagrees with period");

  // Each byte write reaches its field outputs on the next cycle.
  property p_dist_write;
    @(posedge clk) disable iff (!rstn)
      reg_wr && (reg_addr == REG_ADDR[IDX_DIST]) |=>
        ({ext_resistor_q, rx_hf_mode_q, out_powerdown_q} ==
         $past(reg_wdata[BIT_EXTRES:0]));
  endproperty
  a_dist_write: assert property (p_dist_write) // [R20] [R21] [R22]
    else $error("distribution write not applied");

  property p_dac_write;
    @(posedge clk) disable iff (!rstn)
      reg_wr && (reg_addr == REG_ADDR[IDX_DAC_CTL]) |=>
        (dac_shutdown_q == $past(reg_wdata[BIT_DAC_SHDN])) &&
        (dac_fullscale_q[DAC_W-1:DW] == $past(reg_wdata[DAC_W-DW-1:0]));
  endproperty
  a_dac_write: assert property (p_dac_write) // [R6] [R7]
    else $error("auxiliary DAC control write not applied");

  property p_hmode_write;
    @(posedge clk) disable iff (!rstn)
      reg_wr && (reg_addr == REG_ADDR[IDX_HMODE]) |=>
        ({hist_fallback_last_q, hist_persist_q, hist_avg_q} ==
         $past(reg_wdata[BIT_FALLBACK:0]));
  endproperty
  a_hmode_write: assert property (p_hmode_write) // [R17] [R18] [R19]
    else $error("history mode write not applied");

  // Control byte read: live bits as stored, unused bits zero.
  property p_read_dac_ctl;
    @(posedge clk) disable iff (!rstn)
      reg_rd && (reg_addr == REG_ADDR[IDX_DAC_CTL]) |=> reg_rvalid_q &&
        (reg_rdata_q[BIT_DAC_SHDN] == $past(dac_shutdown_q)) &&
        (reg_rdata_q[DAC_W-DW-1:0] == $past(dac_fullscale_q[DAC_W-1:DW])) &&
        ((reg_rdata_q & ~REG_WMASK[IDX_DAC_CTL]) == '0);
  endproperty
  a_read_dac_ctl: assert property (p_read_dac_ctl) // [R7] [R25]
    else $error("auxiliary DAC control read back wrong");

  // Loads, seeds and clears appear only when their cause was seen.
  property p_load_only;
    @(posedge clk) disable iff (!rstn)
      !xfer_wr |=> !tw_load_q;
  endproperty
  a_load_only: assert property (p_load_only) // [R9]
    else $error("tuning word load without a transfer write");

  property p_proc_hold;
    @(posedge clk) disable iff (!rstn)
      !xfer_wr && !freerun_mode |=> $stable(proc_word_q);
  endproperty
  a_proc_hold: assert property (p_proc_hold) // [R9] [R10]
    else $error("processing word changed without cause");

  property p_seed_only;
    @(posedge clk) disable iff (!rstn)
      !(holdover_entry && !history_avail) |=> !seed_valid_q;
  endproperty
  a_seed_only: assert property (p_seed_only) // [R17]
    else $error("holdover seed without missing history");

  property p_clear_only;
    @(posedge clk) disable iff (!rstn)
      !(ref_switch && !hist_persist_q) |=> !hist_clear_q;
  endproperty
  a_clear_only: assert property (p_clear_only) // [R18]
    else $error("history cleared without a reference switch");

endmodule : pcim_reg_bank

/* rtl/pcim_pkg.sv */
// Purpose: Constants for the clock synchroniser configuration bank.
// Assumes: Byte-wide registers on a 16-bit address, one clock domain.
// Notes:   Tables are indexed by the bank's internal register index.
package pcim_pkg;

  localparam int AW          = 16;
  localparam int DW          = 8;
  localparam int NREG        = 37;
  localparam int TWW         = 48;
  localparam int LIM_EVT_W   = 5;
  localparam int REF_PAIRS   = 4;
  localparam int REF_EVT_W   = REF_PAIRS * DW;
  localparam int NOUT        = 4;
  localparam int AVG_W       = 3;
  localparam int DAC_W       = 10;

  // Register indices; multi-byte fields hold their low byte first.
  localparam int IDX_LIM     = 0;
  localparam int IDX_REF0    = 1;
  localparam int IDX_WD0     = 5;
  localparam int IDX_DAC_LO  = 7;
  localparam int IDX_DAC_CTL = 8;
  localparam int IDX_FR0     = 9;
  localparam int IDX_PLLO0   = 15;
  localparam int IDX_PLUP0   = 18;
  localparam int IDX_OLP0    = 21;
  localparam int IDX_FIX0    = 23;
  localparam int IDX_STEP0   = 28;
  localparam int IDX_SLEW0   = 30;
  localparam int IDX_HT0     = 32;
  localparam int IDX_HMODE   = 35;
  localparam int IDX_DIST    = 36;

  // Field bit positions.
  localparam int BIT_XFER     = 0;
  localparam int BIT_DAC_SHDN = 7;
  localparam int BIT_FALLBACK = 4;
  localparam int BIT_PERSIST  = 3;
  localparam int BIT_RXMODE   = 4;
  localparam int BIT_EXTRES   = 5;

  // Multi-byte reset values.
  localparam logic [DAC_W-1:0] DAC_FS_RESET     = 10'h1ff;
  localparam logic [23:0]      PULLIN_UP_RESET  = 24'h0fffff;
  localparam logic [15:0]      STEP_RESET       = 16'h03e8;
  localparam logic [23:0]      HIST_TIMER_RESET = 24'h007530;

  localparam logic [AW-1:0] ADDR_TW_XFER = 16'h0306;

  localparam logic [AW-1:0] REG_ADDR [NREG] = '{
    16'h020c, 16'h020d, 16'h020e, 16'h020f, 16'h0210, 16'h0211,
    16'h0212, 16'h0213, 16'h0214, 16'h0300, 16'h0301, 16'h0302,
    16'h0303, 16'h0304, 16'h0305, 16'h0307, 16'h0308, 16'h0309,
    16'h030a, 16'h030b, 16'h030c, 16'h030d, 16'h030e, 16'h030f,
    16'h0310, 16'h0311, 16'h0312, 16'h0313, 16'h0314, 16'h0315,
    16'h0316, 16'h0317, 16'h0318, 16'h0319, 16'h031a, 16'h031b,
    16'h0400};

  localparam logic [DW-1:0] REG_WMASK [NREG] = '{
    8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h83,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f,
    8'h3f};

  localparam logic [DW-1:0] REG_RESET [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    DAC_FS_RESET[7:0], {6'h00, DAC_FS_RESET[9:8]},
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    PULLIN_UP_RESET[7:0], PULLIN_UP_RESET[15:8], PULLIN_UP_RESET[23:16],
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    STEP_RESET[7:0], STEP_RESET[15:8], 8'h00, 8'h00,
    HIST_TIMER_RESET[7:0], HIST_TIMER_RESET[15:8], HIST_TIMER_RESET[23:16],
    8'h00, 8'h00};

endpackage : pcim_pkg

/* rtl/pcim_evt_gate.sv */
// Purpose: Passes each event pulse on only where its enable bit is set.
// Assumes: Events and enables come from logic on the same clock.
// Notes:   One cycle of latency; output is a registered pulse per event.
module pcim_evt_gate
  import pcim_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rstn,
  // Enables and raw events.
  input  wire logic [W-1:0] mask,
  input  wire logic [W-1:0] evt,
  // Recorded events.
  output logic      [W-1:0] rec_q
);

  typedef struct packed {
    logic [W-1:0] rec;
  } pcim_gate_state_t;

  pcim_gate_state_t s_q;
  pcim_gate_state_t s_d;

  always_comb begin
    s_d     = s_q;
    s_d.rec = evt & mask;
    if (!rstn) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rec_q = s_q.rec;

  // A masked-off event never shows, an enabled one shows next cycle.
  property p_gate;
    @(posedge clk) disable iff (!rstn)
      ##1 (rec_q == ($past(evt) & $past(mask)));
  endproperty
  a_gate: assert property (p_gate) // [R23]
    else $error("event gate output does not match masked events");

endmodule : pcim_evt_gate

/* sim/pcim_host.sv */
// Purpose: Host model that drives the bank's register access port.
// Assumes: Strobes change on the falling edge, one access at a time.
// Notes:   Released address and data lines show inverted last values.
module pcim_host
  import pcim_pkg::*;
(
  // Clock.
  input  wire logic          clk,
  // Access port toward the bank.
  output logic      [AW-1:0] reg_addr,
  output logic               reg_wr,
  output logic               reg_rd,
  output logic      [DW-1:0] reg_wdata,
  input  wire logic [DW-1:0] reg_rdata_q,
  input  wire logic          reg_rvalid_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr  = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = '0;
  end

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d,
                    output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata_q;
    v        = reg_rvalid_q;
  endtask : rd
endmodule : pcim_host

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the configuration bank.
// Assumes: Inputs change on the falling edge of clk.
// Notes:   Expected values come from the register map, not the design.
module tb_top
  import pcim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk, rstn, reg_wr, reg_rd, reg_rvalid_q;
  logic [AW-1:0]        reg_addr;
  logic [DW-1:0]        reg_wdata, reg_rdata_q;
  logic [LIM_EVT_W-1:0] lim_evt, lim_irq_evt_q;
  logic [REF_EVT_W-1:0] ref_evt, ref_irq_evt_q;
  logic                 freerun_mode, holdover_entry, history_avail;
  logic                 ref_switch, watchdog_en_q, dac_shutdown_q;
  logic                 tw_load_q, slew_limit_en_q, hist_fallback_last_q;
  logic                 hist_persist_q, hist_clear_q, seed_valid_q;
  logic                 rx_hf_mode_q, ext_resistor_q, dist_deep_sleep_q;
  logic [TWW-1:0]       last_loop_word, freerun_word_q, proc_word_q;
  logic [TWW-1:0]       seed_word_q;
  logic [15:0]          watchdog_period_q, open_loop_phase_q;
  logic [15:0]          offset_step_q, slew_limit_q;
  logic [23:0]          pullin_lower_q, pullin_upper_q, history_timer_q;
  logic [39:0]          fixed_lock_offset_q;
  logic [DAC_W-1:0]     dac_fullscale_q;
  logic [AVG_W-1:0]     hist_avg_q;
  logic [NOUT-1:0]      out_powerdown_q;
  int                   num_errors, samples_checked;

  localparam logic [15:0] UA [6] = '{16'h020c, 16'h0214, 16'h031b,
                                     16'h0400, 16'h0215, 16'h0306};
  localparam logic [7:0]  UE [6] = '{8'h1f, 8'h83, 8'h1f, 8'h3f, 8'h00,
                                     8'h00};

  pcim_reg_bank dut (.clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q, .reg_rvalid_q, .lim_evt, .ref_evt, .lim_irq_evt_q,
    .ref_irq_evt_q, .freerun_mode, .holdover_entry, .history_avail,
    .ref_switch, .last_loop_word, .watchdog_period_q, .watchdog_en_q,
    .dac_fullscale_q, .dac_shutdown_q, .freerun_word_q, .proc_word_q,
    .tw_load_q, .pullin_lower_q, .pullin_upper_q, .open_loop_phase_q,
    .fixed_lock_offset_q, .offset_step_q, .slew_limit_q, .slew_limit_en_q,
    .history_timer_q, .hist_fallback_last_q, .hist_persist_q, .hist_avg_q,
    .hist_clear_q, .seed_word_q, .seed_valid_q, .out_powerdown_q,
    .rx_hf_mode_q, .ext_resistor_q, .dist_deep_sleep_q);

  pcim_host host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q, .reg_rvalid_q);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk(64'(v), 64'h1, "read valid");
    chk(64'(d), 64'(e), "read data");
  endtask : rchk

  // Writes a field one byte at a time, lowest address first.
  task automatic wf(input logic [15:0] a, input int n, input logic [47:0] v);
    for (int i = 0; i < n; i++) begin
      host.wr(a + 16'(i), v[8*i +: 8]);
    end
  endtask : wf

  task automatic fire(input logic [4:0] l, input logic [31:0] r);
    @(negedge clk);
    lim_evt = l;
    ref_evt = r;
    @(negedge clk);
    lim_evt = '0;
    ref_evt = '0;
  endtask : fire

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end

  initial begin
    {rstn, lim_evt, ref_evt, freerun_mode, ref_switch} = '0;
    {holdover_entry, history_avail} = '0;
    last_loop_word = 48'hfedcba987654;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    rchk(16'h0213, 8'hff);
    rchk(16'h0214, 8'h01);
    rchk(16'h030c, 8'h0f);
    rchk(16'h0314, 8'he8);
    rchk(16'h0318, 8'h30);
    rchk(16'h0319, 8'h75);
    for (int i = 0; i < 5; i++) rchk(16'h020c + 16'(i), 8'h00);
    chk(64'(history_timer_q), 64'd30000, "hist timer");
    chk(64'(pullin_upper_q), 64'h0fffff, "pull-in up");
    chk(64'(pullin_lower_q), 64'h0, "pull-in low");
    chk(64'(offset_step_q), 64'd1000, "step");
    chk(64'(dac_fullscale_q), 64'd511, "dac fs");
    chk(64'({watchdog_en_q, slew_limit_en_q}), 64'h0, "disables");
    chk(64'(freerun_word_q), 64'h0, "free-run");
    chk(64'(hist_avg_q), 64'h0, "avg");
    fire(5'h1f, '1);
    chk(64'({lim_irq_evt_q, ref_irq_evt_q}), 64'h0, "masked");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      host.wr(UA[i], 8'hff);
      rchk(UA[i], UE[i]);
    end
    chk(64'({dac_shutdown_q, dac_fullscale_q}), 64'h7ff, "dac");
    chk(64'({hist_fallback_last_q, hist_persist_q, hist_avg_q}), 64'h1f,
        "hist mode");
    chk(64'({ext_resistor_q, rx_hf_mode_q, dist_deep_sleep_q,
             out_powerdown_q}), 64'h7f, "dist");
    host.wr(16'h0214, 8'h00);
    chk(64'(dac_shutdown_q), 64'h0, "dac on");
    host.wr(16'h0400, 8'h07);
    chk(64'({ext_resistor_q, rx_hf_mode_q, dist_deep_sleep_q,
             out_powerdown_q}), 64'h07, "dist");
    $display("test bits done");
    wf(16'h0211, 2, 48'h1234);
    chk(64'({watchdog_en_q, watchdog_period_q}), 64'h11234, "wd");
    wf(16'h0300, 6, 48'h123456789abc);
    chk(64'(freerun_word_q), 64'h123456789abc, "fr word");
    wf(16'h0307, 6, 48'h0a0b0cc5b6a7);
    chk(64'({pullin_upper_q, pullin_lower_q}), 64'h0a0b0cc5b6a7,
        "pull-in");
    wf(16'h030d, 2, 48'h8001);
    chk(64'(open_loop_phase_q), 64'h8001, "ol phase");
    wf(16'h030f, 5, 48'hf102030405);
    chk(64'(fixed_lock_offset_q), 64'hf102030405, "fixed");
    wf(16'h0314, 4, 48'h00017fff);
    chk(64'({slew_limit_en_q, slew_limit_q, offset_step_q}), 64'h100017fff,
        "step slew");
    wf(16'h0318, 3, 48'h000001);
    chk(64'(history_timer_q), 64'h1, "hist timer");
    $display("test fields done");
    host.wr(16'h0306, 8'h00);
    chk(64'(tw_load_q), 64'h0, "no load");
    host.wr(16'h0306, 8'h01);
    chk(64'({tw_load_q, proc_word_q}), 64'h1123456789abc, "load");
    @(negedge clk);
    chk(64'(tw_load_q), 64'h0, "self clear");
    freerun_mode = 1'b1;
    host.wr(16'h0300, 8'h00);
    @(negedge clk);
    chk(64'(proc_word_q), 64'h123456789a00, "free-run");
    freerun_mode = 1'b0;
    $display("test transfer done");
    for (int f = 0; f < 2; f++) begin
      host.wr(16'h031b, f ? 8'h18 : 8'h00);
      @(negedge clk);
      holdover_entry = 1'b1;
      @(negedge clk);
      holdover_entry = 1'b0;
      chk(64'({seed_valid_q, seed_word_q}),
          {15'h0, 1'b1, f ? last_loop_word : 48'h123456789a00},
          "seed");
      ref_switch = 1'b1;
      @(negedge clk);
      ref_switch = 1'b0;
      chk(64'(hist_clear_q), 64'(f == 0), "clear");
    end
    history_avail = 1'b1;
    holdover_entry = 1'b1;
    @(negedge clk);
    holdover_entry = 1'b0;
    chk(64'(seed_valid_q), 64'h0, "history kept");
    $display("test holdover done");
    wf(16'h020d, 4, 48'h18244281);
    for (int m = 0; m < 2; m++) begin
      host.wr(16'h020c, m ? 8'h0a : 8'h15);
      fire(5'h1f, '1);
      chk(64'(lim_irq_evt_q), m ? 64'h0a : 64'h15, "lim");
      chk(64'(ref_irq_evt_q), 64'h18244281, "ref");
      @(negedge clk);
      chk(64'(lim_irq_evt_q), 64'h0, "pulse");
    end
    $display("test events done");
    wrap_up();
  end
endmodule : tb_top
